// ===== inc/pfc_defs.vh
// register map, field layout and reset values of the pll fabric control block
`ifndef PFC_DEFS_VH
`define PFC_DEFS_VH

// word indexes, byte address is four times the index
`define PFC_REG_CTRL     3'h0
`define PFC_REG_DIVS     3'h1
`define PFC_REG_OUT0     3'h2
`define PFC_REG_OUT1     3'h3
`define PFC_REG_OUT2     3'h4
`define PFC_REG_STAT     3'h5
`define PFC_REG_IRQ_STAT 3'h6
`define PFC_REG_IRQ_MASK 3'h7

// control: feedback mode and output enables
`define PFC_CTRL_FB      1:0
`define PFC_CTRL_EN      4:2
`define PFC_CTRL_RST     5'h04
`define PFC_FB_INTERNAL  2'h0
`define PFC_FB_LOCAL     2'h1
`define PFC_FB_CORE      2'h2

// divider register: pre-divider, multiplier, post-divider
`define PFC_DIVS_N       3:0
`define PFC_DIVS_M       11:4
`define PFC_DIVS_O       15:12
`define PFC_DIVS_RST     16'h1011

// output register: divider and phase in 45 degree steps
`define PFC_OUT_C        8:0
`define PFC_OUT_PH       11:9
`define PFC_OUT_RST      12'h001

// status bits and interrupt causes
`define PFC_IRQ_LOCK     0
`define PFC_IRQ_UNLOCK   1
`define PFC_IRQ_CFGERR   2

// stable detector periods before lock is declared
`define PFC_LOCK_CNT     8'h10
`define PFC_MAX_VCO_MUL  22'h0000ff

`endif

// ===== src/pfc_pll_fabric_control.v
// fabric-side control, lock detection and output dividers of a synthesizing pll
//
// What this block does
// - pass selected reference of four by select
// - reset low holds pll, high starts acquiring
// - lock high on lock, low on loss
// - stopped reference leaves lock indicator unchanged
// - lock indicator unsynchronized, pulses may be short
// - three divided output clocks for global network
// - pre-divider, multiplier, post-divider, output dividers
// - internal feedback frequency relations
// - local/core feedback relations, product at most 255
// - post-divider 1,2,4,8; two or more if several
// - phase shift limited by output divider value
// - feedback mode sets input to output alignment
`timescale 1ns/100ps
`default_nettype none
`include "pfc_defs.vh"

module pfc_pll_fabric_control (
    input  wire        ref_clk_i,
    input  wire        reset_n_i,
    input  wire [3:0]  ref_clock_inputs_i,
    input  wire [1:0]  ref_clock_select_i,
    input  wire        pll_reset_n_i,
    input  wire        feedback_clock_in_i,
    input  wire [2:0]  avs_address_i,
    input  wire        avs_read_i,
    input  wire        avs_write_i,
    input  wire [31:0] avs_writedata_i,
    input  wire [3:0]  avs_byteenable_i,
    output wire        avs_waitrequest_o,
    output wire [31:0] avs_readdata_o,
    output wire        synth_clock_0_o,
    output wire        synth_clock_1_o,
    output wire        synth_clock_2_o,
    output wire        locked_o,
    output wire        irq_o
);

    // ----------------------------------------------------------------
    // register storage
    // ----------------------------------------------------------------
    reg  [4:0]  ctrl_ff;
    reg  [15:0] divs_ff;
    reg  [11:0] out_ff [0:2];
    reg  [2:0]  irq_stat_ff;
    reg  [2:0]  irq_mask_ff;
    reg         ack_ff;
    reg  [31:0] readdata_ff;

    // ----------------------------------------------------------------
    // pll state
    // ----------------------------------------------------------------
    reg         ref_prev_ff;
    reg         fb_prev_ff;
    reg         fb_seen_ff;
    reg  [3:0]  n_cnt_ff;
    reg  [15:0] per_cnt_ff;
    reg  [15:0] per_ff;
    reg  [7:0]  good_ff;
    reg         locked_ff;
    reg         err_prev_ff;
    reg  [15:0] acc_ff;
    wire [2:0]  clk_q;

    wire [1:0]  fb_mode = ctrl_ff[`PFC_CTRL_FB];
    wire [2:0]  clk_en  = ctrl_ff[`PFC_CTRL_EN];
    wire [3:0]  div_n   = divs_ff[`PFC_DIVS_N];
    wire [7:0]  div_m   = divs_ff[`PFC_DIVS_M];
    wire [3:0]  div_o   = divs_ff[`PFC_DIVS_O];

    // ----------------------------------------------------------------
    // byte-lane merge for register writes
    // ----------------------------------------------------------------
    function [31:0] pfc_merge;
        input [31:0] old_v;
        input [31:0] new_v;
        input [3:0]  be;
        integer      k;
        begin
            pfc_merge = old_v;
            for (k = 0; k < 4; k = k + 1) begin
                if (be[k]) begin
                    pfc_merge[k*8 +: 8] = new_v[k*8 +: 8];
                end
            end
        end
    endfunction

    // allowed phase steps for a given output divider
    function pfc_phase_ok;
        input [8:0] c_v;
        input [2:0] ph;
        begin
            if (ph == 3'h0) begin
                pfc_phase_ok = 1'b1;
            end else if (c_v == 9'h002) begin
                pfc_phase_ok = (ph == 3'h2) | (ph == 3'h4) | (ph == 3'h6);
            end else if (c_v == 9'h004) begin
                pfc_phase_ok = (ph == 3'h1) | (ph == 3'h2) | (ph == 3'h3);
            end else if (c_v == 9'h006) begin
                pfc_phase_ok = (ph == 3'h2);
            end else begin
                pfc_phase_ok = 1'b0;
            end
        end
    endfunction

    // ----------------------------------------------------------------
    // configuration checks
    // ----------------------------------------------------------------
    wire [8:0]  c0      = out_ff[0][`PFC_OUT_C];
    wire        o_legal = (div_o == 4'h1) | (div_o == 4'h2) |
                          (div_o == 4'h4) | (div_o == 4'h8);
    wire        multi   = (clk_en == 3'h3) | (clk_en == 3'h5) |
                          (clk_en == 3'h6) | (clk_en == 3'h7);
    wire [21:0] fb_mul  = div_m * div_o * {1'b0, c0};
    wire        fb_ext  = (fb_mode != `PFC_FB_INTERNAL);
    reg         out_bad;
    integer     j;

    always @* begin
        out_bad = 1'b0;
        for (j = 0; j < 3; j = j + 1) begin
            if (out_ff[j][`PFC_OUT_C] == 9'h000) begin
                out_bad = 1'b1;
            end
            if (out_ff[j][`PFC_OUT_C] > 9'h100) begin
                out_bad = 1'b1;
            end
            if (clk_en[j] &&
                !pfc_phase_ok(out_ff[j][`PFC_OUT_C], out_ff[j][`PFC_OUT_PH])) begin
                out_bad = 1'b1;
            end
        end
    end

    wire cfg_err = (div_n == 4'h0) | (div_m == 8'h00) | out_bad |
                   !o_legal | (multi & (div_o == 4'h1)) |
                   (fb_mode == 2'h3) |
                   (fb_ext & (fb_mul > `PFC_MAX_VCO_MUL));

    // pll runs only with reset released and a legal setting
    wire run = pll_reset_n_i & ~cfg_err;

    // ----------------------------------------------------------------
    // reference selection and pre-divider
    // ----------------------------------------------------------------
    // a select change while running may add a false edge; the user
    // keeps the pll in reset across it, so no guard here
    wire ref_lvl  = ref_clock_inputs_i[ref_clock_select_i];
    wire ref_rise = ref_lvl & ~ref_prev_ff;
    wire fb_rise  = feedback_clock_in_i & ~fb_prev_ff;
    wire n_wrap   = (n_cnt_ff >= div_n - 4'h1);
    wire pfd_tick = run & ref_rise & n_wrap;
    wire [15:0] per_now = per_cnt_ff + 16'h0001;
    wire        stable  = (per_now <= per_ff + 16'h0001) &&
                          (per_now + 16'h0001 >= per_ff);
    wire        fb_ok   = (fb_mode != `PFC_FB_CORE) | fb_seen_ff;

    always @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ref_prev_ff <= 1'b0;
            fb_prev_ff  <= 1'b0;
            fb_seen_ff  <= 1'b0;
            n_cnt_ff    <= 4'h0;
            per_cnt_ff  <= 16'h0000;
            per_ff      <= 16'h0000;
            good_ff     <= 8'h00;
            locked_ff   <= 1'b0;
        end else begin
            ref_prev_ff <= ref_lvl;
            fb_prev_ff  <= feedback_clock_in_i;
            if (!run) begin
                n_cnt_ff   <= 4'h0;
                per_cnt_ff <= 16'h0000;
                per_ff     <= 16'h0000;
                good_ff    <= 8'h00;
                locked_ff  <= 1'b0;
                fb_seen_ff <= 1'b0;
            end else begin
                if (per_cnt_ff != 16'hffff) begin
                    per_cnt_ff <= per_now;
                end
                if (fb_rise) begin
                    fb_seen_ff <= 1'b1;
                end
                if (ref_rise) begin
                    n_cnt_ff <= n_wrap ? 4'h0 : n_cnt_ff + 4'h1;
                end
                // lock is judged only on detector edges, so a stopped
                // reference freezes the indicator where it was
                if (pfd_tick) begin
                    per_cnt_ff <= 16'h0000;
                    per_ff     <= per_now;
                    fb_seen_ff <= fb_rise;
                    if (stable && fb_ok) begin
                        if (good_ff == `PFC_LOCK_CNT) begin
                            locked_ff <= 1'b1;
                        end else begin
                            good_ff <= good_ff + 8'h01;
                        end
                    end else begin
                        good_ff   <= 8'h00;
                        locked_ff <= 1'b0;
                    end
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // oscillator model: m_eff ticks spread over one detector period
    // ----------------------------------------------------------------
    wire [7:0]  m_eff  = fb_ext ? fb_mul[7:0] : div_m;
    wire [16:0] acc_up = {1'b0, acc_ff} + {9'h000, m_eff};
    wire        osc_on = run & (per_ff != 16'h0000);
    wire        vco_tick = osc_on & (acc_up >= {1'b0, per_ff});
    // external feedback realigns the oscillator to every detector edge
    wire        resync = ~run | (fb_ext & pfd_tick);

    always @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            acc_ff <= 16'h0000;
        end else if (resync || !osc_on) begin
            acc_ff <= 16'h0000;
        end else if (vco_tick) begin
            acc_ff <= acc_up[15:0] - per_ff;
        end else begin
            acc_ff <= acc_up[15:0];
        end
    end

    // ----------------------------------------------------------------
    // post-divider and output dividers, counted in oscillator ticks
    // ----------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1) begin : g_out
            reg  [12:0] cnt_ff;
            reg         clk_ff;
            wire [12:0] modv  = div_o * out_ff[g][`PFC_OUT_C];
            wire [15:0] offw  = modv * out_ff[g][`PFC_OUT_PH];
            wire [12:0] off   = offw[15:3];
            wire [12:0] start = (off == 13'h0000) ? 13'h0000 : modv - off;
            wire [12:0] nxt_cnt = (cnt_ff + 13'h0001 >= modv) ?
                                  13'h0000 : cnt_ff + 13'h0001;

            always @(posedge ref_clk_i or negedge reset_n_i) begin
                if (!reset_n_i) begin
                    cnt_ff <= 13'h0000;
                    clk_ff <= 1'b0;
                end else if (!clk_en[g] || resync) begin
                    cnt_ff <= start;
                    clk_ff <= 1'b0;
                end else if (modv == 13'h0001) begin
                    // undivided: one high cycle per oscillator tick
                    cnt_ff <= 13'h0000;
                    clk_ff <= vco_tick;
                end else if (vco_tick) begin
                    cnt_ff <= nxt_cnt;
                    clk_ff <= (nxt_cnt < {1'b0, modv[12:1]});
                end
            end

            assign clk_q[g] = clk_ff;
        end
    endgenerate

    assign synth_clock_0_o = clk_q[0];
    assign synth_clock_1_o = clk_q[1];
    assign synth_clock_2_o = clk_q[2];
    // drive the indicator straight out; consumers must resynchronize
    assign locked_o        = locked_ff;

    // ----------------------------------------------------------------
    // avalon-mm slave, one wait cycle per access
    // ----------------------------------------------------------------
    wire req    = avs_read_i | avs_write_i;
    wire wr_acc = avs_write_i & ack_ff;
    wire [31:0] wmask = pfc_merge(32'h00000000, 32'hffffffff, avs_byteenable_i);
    wire [2:0]  w1c   = avs_writedata_i[2:0] & wmask[2:0];
    reg  [31:0] rd_mux;
    // current value of the addressed register with the written lanes merged in
    wire [31:0] wr_merged = pfc_merge(rd_mux, avs_writedata_i, avs_byteenable_i);

    assign avs_waitrequest_o = req & ~ack_ff;
    assign avs_readdata_o    = readdata_ff;

    always @* begin
        case (avs_address_i)
            `PFC_REG_CTRL:     rd_mux = {27'h0000000, ctrl_ff};
            `PFC_REG_DIVS:     rd_mux = {16'h0000, divs_ff};
            `PFC_REG_OUT0:     rd_mux = {20'h00000, out_ff[0]};
            `PFC_REG_OUT1:     rd_mux = {20'h00000, out_ff[1]};
            `PFC_REG_OUT2:     rd_mux = {20'h00000, out_ff[2]};
            `PFC_REG_STAT:     rd_mux = {27'h0000000, run, ref_clock_select_i,
                                         cfg_err, locked_ff};
            `PFC_REG_IRQ_STAT: rd_mux = {29'h00000000, irq_stat_ff};
            `PFC_REG_IRQ_MASK: rd_mux = {29'h00000000, irq_mask_ff};
            default:           rd_mux = 32'h00000000;
        endcase
    end

    // ----------------------------------------------------------------
    // interrupt events, set wins over write-one-to-clear
    // ----------------------------------------------------------------
    reg  locked_prev_ff;
    wire [2:0] ev = {cfg_err & ~err_prev_ff,
                     ~locked_ff & locked_prev_ff,
                     locked_ff & ~locked_prev_ff};
    wire clr_sel = wr_acc & (avs_address_i == `PFC_REG_IRQ_STAT);

    assign irq_o = |(irq_stat_ff & irq_mask_ff);

    always @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ack_ff         <= 1'b0;
            readdata_ff    <= 32'h00000000;
            ctrl_ff        <= `PFC_CTRL_RST;
            divs_ff        <= `PFC_DIVS_RST;
            out_ff[0]      <= `PFC_OUT_RST;
            out_ff[1]      <= `PFC_OUT_RST;
            out_ff[2]      <= `PFC_OUT_RST;
            irq_stat_ff    <= 3'h0;
            irq_mask_ff    <= 3'h0;
            locked_prev_ff <= 1'b0;
            err_prev_ff    <= 1'b0;
        end else begin
            ack_ff         <= req & ~ack_ff;
            locked_prev_ff <= locked_ff;
            err_prev_ff    <= cfg_err;
            if (avs_read_i && !ack_ff) begin
                readdata_ff <= rd_mux;
            end
            irq_stat_ff <= (irq_stat_ff & ~(clr_sel ? w1c : 3'h0)) | ev;
            if (wr_acc) begin
                case (avs_address_i)
                    `PFC_REG_CTRL:     ctrl_ff     <= wr_merged[4:0];
                    `PFC_REG_DIVS:     divs_ff     <= wr_merged[15:0];
                    `PFC_REG_OUT0:     out_ff[0]   <= wr_merged[11:0];
                    `PFC_REG_OUT1:     out_ff[1]   <= wr_merged[11:0];
                    `PFC_REG_OUT2:     out_ff[2]   <= wr_merged[11:0];
                    `PFC_REG_IRQ_MASK: irq_mask_ff <= wr_merged[2:0];
                    default: begin
                    end
                endcase
            end
        end
    end

endmodule // pfc_pll_fabric_control

`default_nettype wire

// ===== verification/pfc_pll_fabric_control_assertions.sv
// concurrent checks on the pll fabric control ports
`timescale 1ns/100ps
`default_nettype none
module pfc_pll_fabric_control_assertions (
    input wire logic        ref_clk_i,
    input wire logic        reset_n_i,
    input wire logic [3:0]  ref_clock_inputs_i,
    input wire logic [1:0]  ref_clock_select_i,
    input wire logic        pll_reset_n_i,
    input wire logic        avs_read_i,
    input wire logic        avs_write_i,
    input wire logic        avs_waitrequest_o,
    input wire logic [31:0] avs_readdata_o,
    input wire logic        synth_clock_0_o,
    input wire logic        synth_clock_1_o,
    input wire logic        synth_clock_2_o,
    input wire logic        locked_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!reset_n_i);
    logic [5:0] run_ff;
    logic [5:0] nxt_run;
    // cycles since the pll reset was last released, saturating
    assign nxt_run = !pll_reset_n_i ? 6'h00 : ((run_ff == 6'h3f) ? run_ff : run_ff + 6'h01);
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            run_ff <= 6'h00;
        end else begin
            run_ff <= nxt_run;
        end
    end
    chk_rst_unlock: assert property (!pll_reset_n_i |=> !locked_o)
        else $error("lock high after pll reset");
    chk_rst_clk_low: assert property (!pll_reset_n_i |=> !(synth_clock_0_o | synth_clock_1_o | synth_clock_2_o))
        else $error("output clock running in pll reset");
    chk_lock_hold: assert property ((pll_reset_n_i && !avs_write_i && $stable(ref_clock_select_i)
        && $stable(ref_clock_inputs_i[ref_clock_select_i]))[*6] |-> $stable(locked_o))
        else $error("lock changed without reference edge");
    chk_lock_late: assert property ($rose(locked_o) |-> run_ff >= 6'h22)
        else $error("lock declared too early");
    chk_rd_wait: assert property ($rose(avs_read_i) |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
        else $error("read wait state wrong");
    chk_wr_wait: assert property (avs_write_i && !$past(avs_write_i) |-> avs_waitrequest_o ##1 (avs_write_i && !avs_waitrequest_o))
        else $error("write wait state wrong");
    chk_idle_nowait: assert property (!(avs_read_i || avs_write_i) |-> !avs_waitrequest_o)
        else $error("waitrequest without request");
    chk_rdata_hold: assert property (!avs_read_i |=> $stable(avs_readdata_o))
        else $error("read data changed without read");
endmodule // pfc_pll_fabric_control_assertions
`default_nettype wire

// ===== verification/pfc_fabric_user.sv
// model of the fabric user logic: references, select, pll reset, feedback
`timescale 1ns/100ps
`default_nettype none
module pfc_fabric_user (
    input  wire logic       ref_clk_i,
    input  wire logic       reset_n_i,
    input  wire logic [1:0] sel_req_i,
    input  wire logic       halt_i,
    input  wire logic       synth_clock_0_i,
    input  wire logic       locked_i,
    output var  logic [3:0] ref_clock_inputs_o,
    output var  logic [1:0] ref_clock_select_o,
    output wire logic       pll_reset_n_o,
    output wire logic       feedback_clock_in_o,
    output wire logic       lock_seen_o
);
    logic [3:0] half_ff [4];
    logic [2:0] hold_ff;
    logic [2:0] sync_ff;
    // reference k has a half period of k+2 cycles; halt freezes the selected one
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ref_clock_inputs_o <= 4'h0;
            ref_clock_select_o <= 2'h0;
            hold_ff <= 3'h4;
            sync_ff <= 3'h0;
            for (int k = 0; k < 4; k++) half_ff[k] <= 4'h0;
        end else begin
            for (int k = 0; k < 4; k++) begin
                if (!(halt_i && ref_clock_select_o == k)) begin
                    half_ff[k] <= (half_ff[k] == 4'(k + 1)) ? 4'h0 : half_ff[k] + 4'h1;
                    if (half_ff[k] == 4'(k + 1)) ref_clock_inputs_o[k] <= ~ref_clock_inputs_o[k];
                end
            end
            hold_ff <= (sel_req_i != ref_clock_select_o) ? 3'h4 : hold_ff - {2'h0, |hold_ff};
            if (sel_req_i != ref_clock_select_o && !pll_reset_n_o) ref_clock_select_o <= sel_req_i;
            sync_ff <= {sync_ff[1:0], locked_i};
        end
    end
    assign pll_reset_n_o       = (hold_ff == 3'h0);
    assign feedback_clock_in_o = synth_clock_0_i;
    assign lock_seen_o         = sync_ff[2];
endmodule // pfc_fabric_user
`default_nettype wire

// ===== verification/pfc_pll_fabric_control_tb_top.sv
// self-checking bench for the pll fabric control block
`timescale 1ns/100ps
`default_nettype none
`include "pfc_defs.vh"
module pfc_pll_fabric_control_tb_top;
    logic        ref_clk_i       = 1'b0;
    logic        reset_n_i       = 1'b0;
    logic [2:0]  avs_address_i   = 3'h0;
    logic        avs_read_i      = 1'b0;
    logic        avs_write_i     = 1'b0;
    logic [31:0] avs_writedata_i = 32'h0;
    logic [1:0]  sel_req         = 2'h0;
    logic        halt            = 1'b0;
    wire  [3:0]  ref_ck;
    wire  [1:0]  ref_sel;
    wire         pll_rst_n, fb_ck, ck0, ck1, ck2, lk, lk_sync, wreq, irq;
    wire  [31:0] rdata;
    int          err_total       = 0;
    int          checks          = 0;
    logic [31:0] q;
    always #10 ref_clk_i = ~ref_clk_i;
    pfc_pll_fabric_control dut_u (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
        .ref_clock_inputs_i(ref_ck), .ref_clock_select_i(ref_sel), .pll_reset_n_i(pll_rst_n),
        .feedback_clock_in_i(fb_ck), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
        .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(4'hf),
        .avs_waitrequest_o(wreq), .avs_readdata_o(rdata), .synth_clock_0_o(ck0),
        .synth_clock_1_o(ck1), .synth_clock_2_o(ck2), .locked_o(lk), .irq_o(irq));
    pfc_fabric_user user_u (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .sel_req_i(sel_req),
        .halt_i(halt), .synth_clock_0_i(ck0), .locked_i(lk), .ref_clock_inputs_o(ref_ck),
        .ref_clock_select_o(ref_sel), .pll_reset_n_o(pll_rst_n), .feedback_clock_in_o(fb_ck),
        .lock_seen_o(lk_sync));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // one avalon access; waitrequest is sampled at the rising edge
    task automatic bus(input logic [2:0] a, input logic wr, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge ref_clk_i);
        avs_address_i <= a;
        avs_writedata_i <= d;
        avs_write_i <= wr;
        avs_read_i <= !wr;
        @(posedge ref_clk_i);
        while (wreq !== 1'b0 && n < 50) begin
            @(posedge ref_clk_i);
            n++;
        end
        check({31'h0, wreq}, 32'h0);
        q = rdata;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
    endtask
    task automatic wait_lock();
        int n;
        n = 0;
        while (lk !== 1'b1 && n < 2000) begin
            @(posedge ref_clk_i);
            n++;
        end
        check({31'h0, lk}, 32'h1);
    endtask
    // four periods of output clock 0, one cycle of jitter allowed
    task automatic meas(input int exp);
        int n, r;
        logic p;
        n = 0;
        r = 0;
        p = 1'b1;
        while (r < 5 && n < 3000) begin
            @(negedge ref_clk_i);
            if (r > 0) n++;
            if (ck0 === 1'b1 && p === 1'b0) r++;
            p = ck0;
        end
        check(32'(n >= 4 * exp - 1 && n <= 4 * exp + 1), 32'h1);
    endtask
    task automatic t_regs();
        logic [2:0]  ra [6] = '{`PFC_REG_CTRL, `PFC_REG_DIVS, `PFC_REG_OUT0, `PFC_REG_OUT1,
                                `PFC_REG_OUT2, `PFC_REG_IRQ_MASK};
        logic [31:0] rv [6] = '{32'h04, 32'h1011, 32'h001, 32'h001, 32'h001, 32'h0};
        for (int i = 0; i < 6; i++) begin
            bus(ra[i], 1'b0, 32'h0);
            check(q, rv[i]);
        end
        bus(`PFC_REG_IRQ_MASK, 1'b1, 32'h7);
        bus(`PFC_REG_IRQ_MASK, 1'b0, 32'h0);
        check(q, 32'h7);
        $display("t_regs done");
    endtask
    task automatic t_lock();
        wait_lock();
        bus(`PFC_REG_STAT, 1'b0, 32'h0);
        check(q & 32'h1, 32'h1);
        check({31'h0, lk_sync}, 32'h1);
        check({31'h0, irq}, 32'h1);
        bus(`PFC_REG_IRQ_MASK, 1'b1, 32'h0);
        @(negedge ref_clk_i);
        check({31'h0, irq}, 32'h0);
        bus(`PFC_REG_IRQ_MASK, 1'b1, 32'h7);
        bus(`PFC_REG_IRQ_STAT, 1'b1, 32'h7);
        @(negedge ref_clk_i);
        check({31'h0, irq}, 32'h0);
        meas(4);
        $display("t_lock done");
    endtask
    task automatic t_stop();
        @(posedge ref_clk_i);
        halt <= 1'b1;
        repeat (100) @(posedge ref_clk_i);
        check({31'h0, lk}, 32'h1);
        halt <= 1'b0;
        $display("t_stop done");
    endtask
    task automatic t_bad();
        logic [2:0]  ba [7] = '{`PFC_REG_OUT0, `PFC_REG_CTRL, `PFC_REG_OUT0, `PFC_REG_OUT0,
                                `PFC_REG_DIVS, `PFC_REG_CTRL, `PFC_REG_CTRL};
        logic [31:0] bd [7] = '{32'h100, 32'h05, 32'h402, 32'h202, 32'h3011, 32'h1c, 32'h07};
        logic [31:0] br [7] = '{32'h100, 32'h04, 32'h402, 32'h001, 32'h1011, 32'h04, 32'h04};
        logic        be [7] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
        for (int i = 0; i < 7; i++) begin
            bus(ba[i], 1'b1, bd[i]);
            repeat (3) @(posedge ref_clk_i);
            bus(`PFC_REG_STAT, 1'b0, 32'h0);
            check((q >> 1) & 32'h1, {31'h0, be[i]});
            bus(ba[i], 1'b1, br[i]);
        end
        bus(`PFC_REG_IRQ_STAT, 1'b0, 32'h0);
        check(q & 32'h4, 32'h4);
        bus(`PFC_REG_IRQ_STAT, 1'b1, 32'h7);
        $display("t_bad done");
    endtask
    task automatic t_select();
        bus(`PFC_REG_OUT0, 1'b1, 32'h003);
        sel_req <= 2'h1;
        repeat (10) @(posedge ref_clk_i);
        wait_lock();
        bus(`PFC_REG_STAT, 1'b0, 32'h0);
        check((q >> 2) & 32'h3, 32'h1);
        meas(18);
        $display("t_select done");
    endtask
    task automatic t_core();
        bus(`PFC_REG_OUT0, 1'b1, 32'h002);
        bus(`PFC_REG_DIVS, 1'b1, 32'h2011);
        bus(`PFC_REG_CTRL, 1'b1, 32'h06);
        repeat (10) @(posedge ref_clk_i);
        wait_lock();
        meas(6);
        $display("t_core done");
    endtask
    task automatic tally_and_finish();
        $display("checks=%0d err_total=%0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge ref_clk_i);
        reset_n_i <= 1'b1;
        t_regs();
        t_lock();
        t_stop();
        t_bad();
        t_select();
        t_core();
        tally_and_finish();
    end
    initial begin
        repeat (40000) @(posedge ref_clk_i);
        err_total++;
        tally_and_finish();
    end
endmodule // pfc_pll_fabric_control_tb_top
bind pfc_pll_fabric_control pfc_pll_fabric_control_assertions chk_u (.ref_clk_i, .reset_n_i,
    .ref_clock_inputs_i, .ref_clock_select_i, .pll_reset_n_i, .avs_read_i, .avs_write_i,
    .avs_waitrequest_o, .avs_readdata_o, .synth_clock_0_o, .synth_clock_1_o, .synth_clock_2_o,
    .locked_o);
`default_nettype wire
